//--- adc_ctrl_pkg.sv
// Package: register map, field positions, carriers and state record for the converter control block
package adc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL   = 8'h04;
   localparam logic [7:0] OFS_RES_HI = 8'h08;
   localparam logic [7:0] OFS_RES_LO = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_PWR   = 7;
   localparam int CTL_JUST  = 6;
   localparam int CTL_EIGHT_BIT_SELECT  = 5;
   localparam int CTL_SGN   = 4;
   localparam int SC_DONE   = 7;
   localparam int SC_IE     = 6;
   localparam int SC_CONT   = 5;

   // ----------------------------------------------------------------
   // Reset values and bus answers
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_RST     = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       done;
      logic [9:0] result;
   } core_in_t;

   typedef struct packed {
      logic clk;
      logic start;
      logic abort;
      logic power;
   } core_out_t;

   typedef enum logic [1:0] {PH_OFF, PH_IDLE, PH_CONV} phase_t;

   typedef struct packed {
      phase_t     phase;
      logic [7:0] ctl;
      logic       irq_en;
      logic       cont;
      logic       done;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [3:0] div;
      logic       cclk;
      logic       start;
      logic       abort;
      logic       irq;
      logic [2:0] dsync;
      logic [9:0] rs1;
      logic [9:0] rs2;
      logic       awready;
      logic       wready;
      logic       aw_hold;
      logic       w_hold;
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic       wlane;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } state_t;

   localparam state_t STATE_RST = state_t'('0);

   // Map a raw 10-bit code onto the high and low result bytes
   function automatic logic [15:0] fmt(input logic [9:0] code, input logic [7:0] ctl);
      logic [9:0] v;
      v = code;
      if (ctl[CTL_SGN] && !ctl[CTL_JUST]) begin
         v[9] = ~code[9];
      end
      if (ctl[CTL_EIGHT_BIT_SELECT]) begin
         fmt = {v[9:2], 8'h00};
      end else if (ctl[CTL_JUST]) begin
         fmt = {6'h00, code[9:8], code[7:0]};
      end else begin
         fmt = {v[9:2], v[1:0], 6'h00};
      end
   endfunction

endpackage

//--- adc_ctrl.sv
// Converter control, completion flag, interrupt request and result formatting behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] With interrupts enabled, request raised after each conversion, results already stored.
// [R2] With interrupts disabled, software polls the done flag.
// [R3] Interrupt request follows done flag gated by interrupt enable.
// [R4] Writing the status register clears the done flag.
// [R5] Reading either result register clears the done flag.
// [R6] Writing the control register aborts a conversion and starts none.
// [R7] Control bit 7 powers the converter; clearing it aborts and powers down (off, not idle).
// [R8] Control bit 6 selects left (0) or right (1) justification.
// [R9] At 8-bit resolution justification only disables signed select; result sits in high byte.
// [R10] Control bit 5 selects 8-bit; code bits 9-2 land on high bits 7-0.
// [R11] Control bit 4 gives signed output by inverting the result MSB.
// [R12] Signed ranges are 0x200..0x1ff (10-bit) and 0x80..0x7f (8-bit).
// [R13] Signed select is ignored under right justification.
// [R14] Control bits 3:0 select the conversion clock divider.
// [R15] Unsigned 10-bit left: full scale 0xff:0xc0, zero 0x00:0x00.
// [R16] 10-bit right: full scale 0x03:0xff, zero all zeros.
// [R17] Signed 8-bit: full scale 0x7f, zero 0x80, low byte zero.
// [R18] Reset clears registers, powers down, ends conversion, clears flag and request.
// [R19] Status write also cancels pending request and, when powered, starts a conversion.
// [R20] Divider factor is (prescale + 1) * 2, from 2 to 32.
// [R21] Continuous mode reconverts after each result; otherwise one per status write.
module adc_ctrl (
   // Clock, reset, enable
   input  wire  logic                    aclk,
   input  wire  logic                    aresetn,
   input  wire  logic                    ce,
   // AXI4-Lite write address
   input  wire  logic                    awvalid,
   output logic                          awready,
   input  wire  logic [7:0]              awaddr,
   // AXI4-Lite write data
   input  wire  logic                    wvalid,
   output logic                          wready,
   input  wire  logic [31:0]             wdata,
   input  wire  logic [3:0]              wstrb,
   // AXI4-Lite write response
   output logic                          bvalid,
   input  wire  logic                    bready,
   output logic [1:0]                    bresp,
   // AXI4-Lite read address
   input  wire  logic                    arvalid,
   output logic                          arready,
   input  wire  logic [7:0]              araddr,
   // AXI4-Lite read data
   output logic                          rvalid,
   input  wire  logic                    rready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   // Analog core
   input  wire  adc_ctrl_pkg::core_in_t  core_in,
   output adc_ctrl_pkg::core_out_t       core_out,
   // Conversion complete request
   output logic                          conv_irq
);

   adc_ctrl_pkg::state_t s_r;
   adc_ctrl_pkg::state_t s_nxt;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        kill;
      logic        restart;
      logic        finish;
      logic [15:0] res;
      kill    = 1'b0;
      restart = 1'b0;
      finish  = 1'b0;
      res     = 16'h0000;
      s_nxt   = s_r;
      s_nxt.start = 1'b0;
      s_nxt.abort = 1'b0;

      // Core signals come from the analog side, so they are synchronised
      s_nxt.dsync = {s_r.dsync[1:0], core_in.done};
      s_nxt.rs1   = core_in.result;
      s_nxt.rs2   = s_r.rs1;

      // Write address and data are taken independently, in either order
      if (awvalid && s_r.awready) begin
         s_nxt.aw_hold = 1'b1;
         s_nxt.waddr   = awaddr;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.w_hold = 1'b1;
         s_nxt.wdata  = wdata[7:0];
         s_nxt.wlane  = wstrb[0];
      end

      if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
         s_nxt.aw_hold = 1'b0;
         s_nxt.w_hold  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = adc_ctrl_pkg::RESP_OKAY;
         case (s_r.waddr)
            adc_ctrl_pkg::OFS_STATUS: begin
               if (s_r.wlane) begin
                  s_nxt.irq_en = s_r.wdata[adc_ctrl_pkg::SC_IE];
                  s_nxt.cont   = s_r.wdata[adc_ctrl_pkg::SC_CONT];
                  s_nxt.done   = 1'b0;                                          // [R4] [R19]
                  if (s_r.phase != adc_ctrl_pkg::PH_OFF) begin
                     s_nxt.phase = adc_ctrl_pkg::PH_CONV;                       // [R19] [R21]
                     s_nxt.start = 1'b1;
                     restart     = 1'b1;
                  end
               end
            end
            adc_ctrl_pkg::OFS_CTRL: begin
               if (s_r.wlane) begin
                  s_nxt.ctl   = s_r.wdata;
                  kill        = 1'b1;
                  s_nxt.abort = (s_r.phase == adc_ctrl_pkg::PH_CONV);         // [R6]
                  if (s_r.wdata[adc_ctrl_pkg::CTL_PWR]) begin
                     s_nxt.phase = adc_ctrl_pkg::PH_IDLE;                       // [R6]
                  end else begin
                     s_nxt.phase = adc_ctrl_pkg::PH_OFF;                        // [R7]
                  end
               end
            end
            adc_ctrl_pkg::OFS_RES_HI,
            adc_ctrl_pkg::OFS_RES_LO: begin
               s_nxt.bresp = adc_ctrl_pkg::RESP_OKAY;
            end
            default: begin
               s_nxt.bresp = adc_ctrl_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_hold && !s_nxt.bvalid;

      // Read channel: one read outstanding, answered one edge after arrival
      if (arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = adc_ctrl_pkg::RESP_OKAY;
         case (araddr)
            adc_ctrl_pkg::OFS_STATUS: begin
               s_nxt.rdata = {s_r.done, s_r.irq_en, s_r.cont, 5'h00};          // [R2]
            end
            adc_ctrl_pkg::OFS_CTRL: begin
               s_nxt.rdata = s_r.ctl;
            end
            adc_ctrl_pkg::OFS_RES_HI: begin
               s_nxt.rdata = s_r.res_hi;
               s_nxt.done  = 1'b0;                                              // [R5]
            end
            adc_ctrl_pkg::OFS_RES_LO: begin
               s_nxt.rdata = s_r.res_lo;
               s_nxt.done  = 1'b0;                                              // [R5]
            end
            default: begin
               s_nxt.rdata = 8'h00;
               s_nxt.rresp = adc_ctrl_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // ----------------------------------------------------------------
      // Conversion clock: toggles every (prescale + 1) cycles
      // ----------------------------------------------------------------
      if (s_nxt.phase == adc_ctrl_pkg::PH_OFF) begin
         s_nxt.div  = 4'h0;                                                     // [R7]
         s_nxt.cclk = 1'b0;
      end else if (s_r.div == s_r.ctl[3:0]) begin
         s_nxt.div  = 4'h0;                                                     // [R14] [R20]
         s_nxt.cclk = ~s_r.cclk;
      end else begin
         s_nxt.div = s_r.div + 4'h1;                                            // [R20]
      end

      // ----------------------------------------------------------------
      // Completion: evaluated after the clears so a new result wins
      // ----------------------------------------------------------------
      finish = (s_r.phase == adc_ctrl_pkg::PH_CONV) && s_r.dsync[1] && !s_r.dsync[2] && !kill;
      if (finish) begin
         res          = adc_ctrl_pkg::fmt(s_r.rs2, s_r.ctl);                    // [R8] [R9] [R10] [R11] [R12] [R13]
         s_nxt.res_hi = res[15:8];                                              // [R15] [R16] [R17]
         s_nxt.res_lo = res[7:0];
         s_nxt.done   = 1'b1;                                                   // [R1]
         if (s_r.cont) begin
            s_nxt.start = 1'b1;                                                 // [R21]
         end else if (!restart) begin
            s_nxt.phase = adc_ctrl_pkg::PH_IDLE;                                // [R21]
         end
      end

      // Request is registered together with the flag, so both change on the same edge
      s_nxt.irq = s_nxt.done && s_nxt.irq_en;                                   // [R1] [R3]
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= adc_ctrl_pkg::STATE_RST;                                        // [R18]
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign awready        = s_r.awready;
   assign wready         = s_r.wready;
   assign bvalid         = s_r.bvalid;
   assign bresp          = s_r.bresp;
   assign arready        = s_r.arready;
   assign rvalid         = s_r.rvalid;
   assign rdata          = {24'h000000, s_r.rdata};
   assign rresp          = s_r.rresp;
   assign core_out.clk   = s_r.cclk;
   assign core_out.start = s_r.start;
   assign core_out.abort = s_r.abort;
   assign core_out.power = s_r.ctl[adc_ctrl_pkg::CTL_PWR];                      // [R7]
   assign conv_irq       = s_r.irq;

endmodule

`default_nettype wire

//--- adc_ctrl_props.sv
// Checker: port-level timing relations of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
   // Clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire logic                    ce,
   // Bus handshakes
   input wire logic                    awvalid,
   input wire logic                    awready,
   input wire logic [7:0]              awaddr,
   input wire logic                    wvalid,
   input wire logic                    wready,
   input wire logic [3:0]              wstrb,
   input wire logic                    arvalid,
   input wire logic                    arready,
   input wire logic [7:0]              araddr,
   // Core and request
   input wire adc_ctrl_pkg::core_out_t core_out,
   input wire adc_ctrl_pkg::core_in_t  core_in,
   input wire logic                    conv_irq
);
   default clocking @(posedge aclk); endclocking
   // A frozen clock enable stalls every relation below, so those cycles are skipped
   default disable iff (!aresetn || !ce);
   wire logic wt   = awvalid && awready && wvalid && wready && wstrb[0];
   wire logic w_st = wt && awaddr == adc_ctrl_pkg::OFS_STATUS;
   wire logic w_ct = wt && awaddr == adc_ctrl_pkg::OFS_CTRL;
   wire logic r_rs = arvalid && arready && (araddr == adc_ctrl_pkg::OFS_RES_HI || araddr == adc_ctrl_pkg::OFS_RES_LO);
   property p_rst; $rose(aresetn) |-> !conv_irq && !core_out.power && !core_out.start; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_abort; core_out.abort |-> !core_out.start; endproperty
   a_abort: assert property (p_abort) else $error("start with abort");
   property p_ctl; w_ct |-> ##2 !core_out.start; endproperty
   a_ctl: assert property (p_ctl) else $error("control write started a conversion");
   property p_st; w_st && core_out.power |-> ##2 core_out.start; endproperty
   a_st: assert property (p_st) else $error("status write gave no start");
   // A completion landing on the clearing edge wins, so that case is left out
   property p_stirq; w_st && !$past(core_in.done) |-> ##2 !conv_irq; endproperty
   a_stirq: assert property (p_stirq) else $error("request kept after status write");
   property p_rdclr; r_rs && !$past(core_in.done, 2) |=> !conv_irq; endproperty
   a_rdclr: assert property (p_rdclr) else $error("request kept after result read");
   property p_pwr; !core_out.power |-> !core_out.clk; endproperty
   a_pwr: assert property (p_pwr) else $error("clock runs while powered off");
   property p_pulse; core_out.start |=> !core_out.start; endproperty
   a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
endmodule
bind adc_ctrl adc_ctrl_props adc_ctrl_props_i (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
   .wstrb, .arvalid, .arready, .araddr, .core_out, .core_in, .conv_irq);
`default_nettype wire

//--- adc_core_model.sv
// Partner model: analog core answering start pulses with a code and a completion edge
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   // Clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // Controls
   input wire adc_ctrl_pkg::core_out_t core_out,
   input wire logic [9:0]              code,
   input wire logic                    slow,
   // Answer
   output adc_ctrl_pkg::core_in_t      core_in
);
   logic [4:0] cnt_r;
   logic       busy_r;
   initial core_in = '0;
   // Code loads at start so it is stable long before done; inverted once done drops
   always @(posedge aclk) begin
      cnt_r <= cnt_r - 5'h01;
      if (!aresetn || core_out.abort || !core_out.power) begin
         busy_r <= 1'h0;
         core_in.done <= 1'h0;
      end else if (core_out.start) begin
         busy_r <= 1'h1;
         cnt_r <= slow ? 5'h14 : 5'h03;
         core_in.done <= 1'h0;
         core_in.result <= code;
      end else if (busy_r && cnt_r == 5'h00) begin
         busy_r <= 1'h0;
         cnt_r <= 5'h06;
         core_in.done <= 1'h1;
      end else if (!busy_r && core_in.done && cnt_r == 5'h00) begin
         core_in.done <= 1'h0;
         core_in.result <= ~core_in.result;
      end
   end
endmodule
`default_nettype wire

//--- adc_ctrl_test.sv
// Testbench: bus access, result formats, abort, continuous mode, prescale, reset
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_test;
   logic aclk = 0, aresetn = 0, ce = 1, slow = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, conv_irq;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [7:0] kt[7] = '{8'h80, 8'h90, 8'hc0, 8'hd0, 8'ha0, 8'hb0, 8'hf0};
   logic [3:0] wstrb = '0;
   logic [31:0] wdata = '0, rdata, rng = 32'h3acc;
   logic [1:0] bresp, rresp, qb[$];
   logic [9:0] code = '0;
   logic [15:0] f;
   logic [33:0] qr[$];
   int n_mismatch = 0, samples_checked = 0, cyc = 0, n, n_abort = 0;
   adc_ctrl_pkg::core_in_t core_in;
   adc_ctrl_pkg::core_out_t core_out;
   adc_ctrl adc_ctrl_i (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .core_in, .core_out, .conv_irq);
   adc_core_model adc_core_model_i (.aclk, .aresetn, .core_out, .code, .slow, .core_in);
   initial forever #12.5 aclk = ~aclk;
   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] r = adc_ctrl_pkg::RESP_OKAY);
      bit ta = 0, tw = 0;
      qb.push_back(r);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) begin
            awvalid <= 1'h0;
            ta = 1;
         end
         if (wready) begin
            wvalid <= 1'h0;
            tw = 1;
         end
      end while (!(ta && tw));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] d, logic [1:0] r = adc_ctrl_pkg::RESP_OKAY);
      qr.push_back({r, 24'h000000, d});
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic span(logic v);
      do begin
         @(posedge aclk);
         n++;
      end while (core_out.clk == v);
   endtask
   function automatic logic [15:0] ef(logic [9:0] c, logic [7:0] m);
      logic [9:0] v;
      v = c ^ {m[4] & ~m[6], 9'h000};
      if (m[5]) return {v[9:2], 8'h00};
      return m[6] ? {6'h00, c} : {v, 6'h00};
   endfunction
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Answers are compared in the order their requests were issued
   always @(posedge aclk) begin
      if (bvalid && bready) chk("bresp", 34'(qb.pop_front()), 34'(bresp));
      if (rvalid && rready) chk("rdata", qr.pop_front(), {rresp, rdata});
   end
   always @(posedge aclk) begin
      cyc++;
      if (core_out.abort) n_abort++;
      if (cyc == 10000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(adc_ctrl_pkg::OFS_CTRL, 8'h00);
      for (int i = 0; i < 21; i++) begin
         rng = xs(rng);
         code <= i < 7 ? 10'h3ff : i < 14 ? 10'h000 : rng[9:0];
         wr(adc_ctrl_pkg::OFS_CTRL, kt[i % 7]);
         wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
         do @(posedge aclk); while (!conv_irq);
         f = ef(code, kt[i % 7]);
         rd(adc_ctrl_pkg::OFS_STATUS, 8'hc0);
         rd(adc_ctrl_pkg::OFS_RES_LO, f[7:0]);
         rd(adc_ctrl_pkg::OFS_STATUS, 8'h40);
         rd(adc_ctrl_pkg::OFS_RES_HI, f[15:8]);
      end
      slow <= 1'h1;
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h00);
      repeat (40) @(posedge aclk);
      chk("irq", 34'h0, 34'(conv_irq));
      rd(adc_ctrl_pkg::OFS_STATUS, 8'h80);
      rd(adc_ctrl_pkg::OFS_RES_HI, f[15:8]);
      rd(adc_ctrl_pkg::OFS_STATUS, 8'h00);
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      repeat (40) @(posedge aclk);
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      chk("irq", 34'h0, 34'(conv_irq));
      wr(adc_ctrl_pkg::OFS_CTRL, 8'h80);
      repeat (40) @(posedge aclk);
      rd(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      chk("abort", 34'h1, 34'(n_abort));
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      wr(adc_ctrl_pkg::OFS_CTRL, 8'h00);
      repeat (40) @(posedge aclk);
      rd(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      chk("abort", 34'h2, 34'(n_abort));
      slow <= 1'h0;
      wr(adc_ctrl_pkg::OFS_CTRL, 8'h80);
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h20);
      repeat (2) do @(posedge aclk); while (!core_out.start);
      rd(adc_ctrl_pkg::OFS_STATUS, 8'ha0);
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h00);
      repeat (20) @(posedge aclk);
      for (int p = 0; p < 16; p += 5) begin
         wr(adc_ctrl_pkg::OFS_CTRL, 8'h80 | 8'(p));
         span(1'h1);
         span(1'h0);
         n = 0;
         span(1'h1);
         span(1'h0);
         chk("div", 34'((p + 1) * 2), 34'(n));
      end
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      // Completion pulse falls entirely inside the frozen window, so it must be missed
      ce <= 1'h0;
      repeat (20) @(posedge aclk);
      ce <= 1'h1;
      repeat (10) @(posedge aclk);
      chk("ce", 34'h0, 34'(conv_irq));
      wr(adc_ctrl_pkg::OFS_STATUS, 8'h40);
      do @(posedge aclk); while (!conv_irq);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk("irq", 34'h0, 34'(conv_irq));
      rd(adc_ctrl_pkg::OFS_CTRL, 8'h00);
      wr(adc_ctrl_pkg::OFS_RES_HI, 8'h5a);
      rd(adc_ctrl_pkg::OFS_RES_HI, 8'h00);
      wr(8'h10, 8'h5a, adc_ctrl_pkg::RESP_SLVERR);
      rd(8'h10, 8'h00, adc_ctrl_pkg::RESP_SLVERR);
      print_verdict();
   end
endmodule
`default_nettype wire
